// ### pfoc_top.sv
// Partitioned flash read path, write engine and command registers
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pfoc_top (
  // Clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    srst_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [11:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // Host flash bus pins
  input  wire pfoc_pkg::pfoc_host_s    host_in,
  input  wire logic                    burst_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    supply_low_in,
  input  wire logic [1:0]              density_in,
  // Array interface
  output pfoc_pkg::pfoc_arr_s          arr_out,
  input  wire logic [15:0]             arr_data_in,
  // Host data and status pins
  output logic      [15:0]             data_out,
  output logic                         data_oe_out,
  output logic                         wait_out,
  output logic                         standby_out,
  output logic                         power_save_out
);
  import pfoc_pkg::*;

  // Pin synchronisers, two stages each
  pfoc_host_s host_s1, host_q;                 // Host bus stages
  logic [2:0] pin_s1, pin_q;                   // Burst clock, reset pin, supply
  always_ff @(posedge mclk_in) begin
    host_s1 <= host_in;
    host_q  <= host_s1;
    pin_s1  <= {burst_clk_in, rst_n_in, supply_low_in};
    pin_q   <= pin_s1;
  end
  logic pin_rst, supply_low, bclk_q, bclk_d;
  assign pin_rst    = srst_in | ~pin_q[1];     // Pin reset joins system reset
  assign supply_low = pin_q[0];
  assign bclk_q     = pin_q[2];
  always_ff @(posedge mclk_in) bclk_d <= bclk_q;
  logic bclk_rise;                             // Valid burst clock edge
  assign bclk_rise = bclk_q & ~bclk_d;

  // Registers
  logic [15:0]       read_setup;               // Read setup register
  logic [ADDR_W-1:0] cmd_addr;                 // Command target
  logic [DATA_W-1:0] cmd_data;                 // Program data
  logic [PART_W-1:0] stat_sel;                 // Partition chosen for status reads
  logic [7:0]        part_stat [NPART];        // Per-partition status
  logic [2:0]        otp_sel;                  // OTP word index
  logic [OTP_HALF-1:0] otp_user;               // User OTP cells
  logic [OTP_HALF-1:0] otp_written;            // User cells already programmed
  logic [255:0]      blk_lock, blk_down;       // Main block protection

  // APB decode
  logic apb_wr, apb_rd, addr_ok;
  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign apb_rd = psel_in & ~pwrite_in;
  assign addr_ok = paddr_in <= REG_OTP_DATA && paddr_in[1:0] == 2'b00;
  assign pready_out  = 1'b1;                   // Zero wait state slave
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // Partition count from density strap
  logic [5:0] part_cnt;
  always_comb begin
    unique case (density_in)
      2'b00:   part_cnt = 6'(PARTS_32M);
      2'b01:   part_cnt = 6'(PARTS_64M);
      default: part_cnt = 6'(PARTS_128M);
    endcase
  end

  // Read setup register: reset to page mode
  always_ff @(posedge mclk_in) begin
    if (pin_rst) begin
      read_setup <= RS_RESET;
    end else if (apb_wr && paddr_in == REG_READ_SETUP) begin
      read_setup <= pwdata_in[15:0];
    end
  end

  // Command address, data and OTP select
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cmd_addr <= '0;
      cmd_data <= '0;
      otp_sel  <= '0;
    end else if (apb_wr) begin
      if (paddr_in == REG_ADDR) cmd_addr <= pwdata_in[ADDR_W-1:0];
      if (paddr_in == REG_DATA) cmd_data <= pwdata_in[DATA_W-1:0];
      if (paddr_in == REG_OTP_SEL) otp_sel <= pwdata_in[2:0];
    end
  end
  // Command decode
  logic       cmd_wr;
  pfoc_cmd_e  cmd;
  assign cmd_wr = apb_wr && paddr_in == REG_CMD;
  assign cmd    = pfoc_cmd_e'(pwdata_in[3:0]);
  logic [PART_W-1:0] tgt_part;
  logic [7:0]        tgt_blk;
  logic              tgt_param;                // Address hits a small block
  assign tgt_part  = cmd_addr[PART_LSB +: PART_W];
  assign tgt_blk   = cmd_addr[BLK_LSB +: 8];
  assign tgt_param = tgt_blk == 8'h00;                 // Bottom parameter blocks

  // Write engine
  pfoc_eng_e         eng, next_eng;
  logic [CNT_W-1:0]  eng_cnt;                  // Remaining busy cycles
  logic [CNT_W-1:0]  ers_left;                 // Erase time saved when a nested program starts
  logic [PART_W-1:0] busy_part;                // Partition running the current algorithm
  logic [7:0]        ers_blk;                  // Block whose erase is suspended
  logic [PART_W-1:0] ers_part;
  logic              op_ok, go_prog, go_erase, blk_prot;
  assign blk_prot = blk_lock[tgt_blk];
  // Operation allowed: supply good, block unlocked, part in range
  assign op_ok = !supply_low && !blk_prot &&
                 6'(tgt_part) < part_cnt;
  assign go_prog  = cmd_wr && cmd == CMD_PROGRAM && op_ok &&
                    (eng == ENG_IDLE ||
                     (eng == ENG_ERS_SUSP &&
                      !(tgt_blk == ers_blk && tgt_part == ers_part)));
  assign go_erase = cmd_wr && cmd == CMD_ERASE && op_ok && eng == ENG_IDLE;

  // Engine next state
  always_comb begin
    next_eng = eng;
    unique case (eng)
      ENG_IDLE: begin
        if (go_prog) next_eng = ENG_PROG;
        else if (go_erase) next_eng = ENG_ERASE;
      end
      ENG_PROG: begin
        if (eng_cnt == '0) next_eng = ENG_IDLE;
      end
      ENG_ERASE: begin
        if (eng_cnt == '0) next_eng = ENG_IDLE;
        else if (cmd_wr && cmd == CMD_SUSPEND) next_eng = ENG_ERS_SUSP;
      end
      ENG_ERS_SUSP: begin
        if (go_prog) next_eng = ENG_NEST_PROG;
        else if (cmd_wr && cmd == CMD_RESUME) next_eng = ENG_ERASE;
      end
      ENG_NEST_PROG: begin
        if (eng_cnt == '0) next_eng = ENG_ERS_SUSP;
        else if (cmd_wr && cmd == CMD_SUSPEND) next_eng = ENG_BOTH_SUSP;
      end
      ENG_BOTH_SUSP: begin
        if (cmd_wr && cmd == CMD_RESUME) next_eng = ENG_NEST_PROG;
      end
      default: next_eng = ENG_IDLE;
    endcase
  end

  // Engine state and timing; pin reset aborts the algorithm
  always_ff @(posedge mclk_in) begin
    if (pin_rst) begin
      eng       <= ENG_IDLE;
      eng_cnt   <= '0;
      ers_left  <= '0;
      busy_part <= '0;
      ers_blk   <= '0;
      ers_part  <= '0;
    end else begin
      eng <= next_eng;
      if (go_erase) begin
        eng_cnt   <= CNT_W'(ERASE_CYC);
        busy_part <= tgt_part;
        ers_blk   <= tgt_blk;
        ers_part  <= tgt_part;
      end else if (go_prog) begin
        if (eng == ENG_ERS_SUSP) ers_left <= eng_cnt;
        eng_cnt   <= CNT_W'(PROG_CYC);
        busy_part <= tgt_part;
      end else if (eng == ENG_NEST_PROG && eng_cnt == '0) begin
        eng_cnt   <= ers_left;                   // Restore erase time
        busy_part <= ers_part;
      end else if ((eng == ENG_PROG || eng == ENG_ERASE || eng == ENG_NEST_PROG)
                   && eng_cnt != '0 && next_eng == eng) begin
        eng_cnt <= eng_cnt - 1'b1;               // Frozen while suspended
      end
    end
  end

  // Per-partition status registers
  logic [NPART-1:0] stat_sel_hit;
  generate
    for (genvar p = 0; p < NPART; p++) begin : g_stat
      logic mine;
      assign mine = busy_part == PART_W'(p) && eng != ENG_IDLE;
      assign stat_sel_hit[p] = mine;
      always_ff @(posedge mclk_in) begin
        if (pin_rst) begin
          part_stat[p] <= ST_RESET;
        end else if (cmd_wr && cmd == CMD_CLR_STAT && tgt_part == PART_W'(p)) begin
          part_stat[p] <= ST_RESET;
        end else begin
          // Busy when this partition owns a running algorithm
          part_stat[p][ST_READY] <= !(mine &&
              (next_eng == ENG_PROG || next_eng == ENG_ERASE ||
               next_eng == ENG_NEST_PROG));
          part_stat[p][ST_ERS_SUSP] <= (next_eng == ENG_ERS_SUSP ||
              next_eng == ENG_NEST_PROG || next_eng == ENG_BOTH_SUSP)
              && ers_part == PART_W'(p);
          part_stat[p][ST_PRG_SUSP] <= next_eng == ENG_BOTH_SUSP && mine;
          // Program and erase failure flags are sticky until cleared; supply and lock bits show the last refusal
          if (cmd_wr && tgt_part == PART_W'(p) && (cmd == CMD_PROGRAM ||
              cmd == CMD_ERASE) && !op_ok) begin
            part_stat[p][ST_SUPPLY_LOW] <= supply_low;
            part_stat[p][ST_LOCKED]     <= blk_prot;
            if (cmd == CMD_PROGRAM) part_stat[p][ST_PRG_FAIL] <= 1'b1;
            else part_stat[p][ST_ERS_FAIL] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Block protection; lock-down only cleared by reset
  always_ff @(posedge mclk_in) begin
    if (pin_rst) begin
      blk_lock <= '1;
      blk_down <= '0;
    end else if (cmd_wr) begin
      if (cmd == CMD_LOCK) blk_lock[tgt_blk] <= 1'b1;
      if (cmd == CMD_UNLOCK && !blk_down[tgt_blk])
        blk_lock[tgt_blk] <= 1'b0;
      if (cmd == CMD_LOCKDOWN) begin
        blk_lock[tgt_blk] <= 1'b1;
        blk_down[tgt_blk] <= 1'b1;
      end
    end
  end

  // User OTP cells; each bit programmable once, zero going to one
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      otp_user    <= '0;                         // Stands in for erased cells
      otp_written <= '0;
    end else if (cmd_wr && cmd == CMD_OTP_PROG && !supply_low && otp_sel[2]) begin
      otp_user[otp_sel[1:0]*16 +: 16]    <= otp_user[otp_sel[1:0]*16 +: 16] |
          (cmd_data & ~otp_written[otp_sel[1:0]*16 +: 16]);
      otp_written[otp_sel[1:0]*16 +: 16] <= otp_written[otp_sel[1:0]*16 +: 16] |
          cmd_data;
    end
  end
  logic [OTP_W-1:0] otp_all;
  assign otp_all = {otp_user, OTP_FACTORY};

  // APB read data
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      prdata_out <= '0;
      stat_sel   <= '0;
    end else begin
      if (apb_wr && paddr_in == REG_ADDR) stat_sel <= pwdata_in[PART_LSB +: PART_W];
      if (apb_rd && !penable_in) begin
        unique case (paddr_in)
          REG_READ_SETUP: prdata_out <= {16'h0000, read_setup};
          REG_ADDR:       prdata_out <= 32'(cmd_addr);
          REG_DATA:       prdata_out <= {16'h0000, cmd_data};
          REG_STATUS:     prdata_out <= {24'h000000, part_stat[stat_sel]};
          REG_ENGINE:     prdata_out <= {18'h00000, part_cnt, 2'b00,  // Count kept off state
                                        eng, 3'b000};
          REG_OTP_SEL:    prdata_out <= {29'h00000000, otp_sel};
          REG_OTP_DATA:   prdata_out <= {16'h0000, otp_all[otp_sel*16 +: 16]};
          default:        prdata_out <= '0;
        endcase
      end
    end
  end

  // Host read path: page mode or burst mode
  logic              sync_mode;
  logic [ADDR_W-1:0] burst_addr;               // Internal burst counter
  logic [2:0]        lat_cnt;                  // Initial latency remaining
  logic              half_ph;                  // Second clock phase toggle
  logic              in_burst, data_vld;
  assign sync_mode = read_setup[RS_SYNC];
  always_ff @(posedge mclk_in) begin
    if (pin_rst || host_q.ce_n) begin
      burst_addr <= '0;
      lat_cnt    <= '0;
      half_ph    <= 1'b0;
      in_burst   <= 1'b0;
      data_vld   <= 1'b0;
    end else if (!host_q.adv_n) begin
      burst_addr <= host_q.addr;               // Address latch
      lat_cnt    <= read_setup[RS_LAT_LSB +: 3];
      half_ph    <= 1'b0;
      in_burst   <= sync_mode;
      data_vld   <= !sync_mode;
    end else if (in_burst && bclk_rise) begin
      if (lat_cnt != '0) begin
        lat_cnt  <= lat_cnt - 1'b1;
        data_vld <= 1'b0;
      end else begin
        half_ph  <= read_setup[RS_HALF_RATE] ? ~half_ph : 1'b0;
        data_vld <= 1'b1;
        // Counter wraps freely through partition edges
        if (!half_ph) burst_addr <= burst_addr + 1'b1;
      end
    end else if (!in_burst) begin
      burst_addr <= host_q.addr;               // Page mode follows pins
      data_vld   <= !host_q.oe_n;
    end
  end

  // Array fetch and host data output
  assign arr_out.req  = !host_q.ce_n && !host_q.oe_n && !pin_rst;
  assign arr_out.addr = burst_addr;
  always_ff @(posedge mclk_in) begin
    if (pin_rst) begin
      data_out    <= '0;
      data_oe_out <= 1'b0;
    end else begin
      data_out    <= arr_data_in;
      data_oe_out <= !host_q.ce_n && !host_q.oe_n;
    end
  end

  // Wait pin: asserted in burst mode while data not yet valid, polarity programmable
  always_ff @(posedge mclk_in) begin
    if (pin_rst) begin
      wait_out <= 1'b0;
    end else begin
      wait_out <= (in_burst && !data_vld) ~^ read_setup[RS_WAIT_POL];
    end
  end

  // Power states
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      standby_out    <= 1'b1;
      power_save_out <= 1'b0;
    end else begin
      standby_out    <= host_q.ce_n || !pin_q[1];
      power_save_out <= !host_q.ce_n && host_q.oe_n && eng == ENG_IDLE;
    end
  end
endmodule
`default_nettype wire

// ### pfoc_pkg.sv
// Package of constants and types for the partitioned flash operation control block
package pfoc_pkg;
  // Array geometry
  localparam int unsigned PART_MBIT       = 4;           // Partition size in Mbit
  localparam int unsigned MAIN_BLK_KWORD  = 32;          // Main block size in Kword
  localparam int unsigned PARAM_BLK_KWORD = 4;           // Parameter block size in Kword
  localparam int unsigned PARAM_BLK_CNT   = 8;           // Parameter blocks per device
  localparam int unsigned PARTS_32M       = 8;           // Partitions at 32 Mbit
  localparam int unsigned PARTS_64M       = 16;          // Partitions at 64 Mbit
  localparam int unsigned PARTS_128M      = 32;          // Partitions at 128 Mbit
  localparam int unsigned NPART           = PARTS_128M;  // Largest density built
  localparam int unsigned PART_W          = 5;           // Partition index width
  localparam int unsigned ADDR_W          = 23;          // Word address width
  localparam int unsigned PART_LSB        = 18;          // 256 Kword per partition
  localparam int unsigned BLK_LSB         = 15;          // 32 Kword block index
  localparam int unsigned DATA_W          = 16;          // Host word, two bytes
  localparam int unsigned OTP_W           = 128;         // One-time protection bits
  localparam int unsigned OTP_HALF        = 64;          // Factory / user split
  localparam logic [63:0] OTP_FACTORY     = 64'h0123456789ABCDEF; // Arbitrary value

  // Write engine timing
  localparam int unsigned PROG_TIME_NS    = 2000;        // Modelled program time
  localparam int unsigned ERASE_TIME_NS   = 20000;       // Modelled erase time
  localparam int unsigned CLK_NS          = 4;           // Clock period
  localparam int unsigned PROG_CYC        = PROG_TIME_NS / CLK_NS;
  localparam int unsigned ERASE_CYC       = ERASE_TIME_NS / CLK_NS;
  localparam int unsigned CNT_W           = 16;

  // APB register offsets
  localparam logic [11:0] REG_READ_SETUP  = 12'h000;     // Read setup register
  localparam logic [11:0] REG_CMD         = 12'h004;     // Command entry
  localparam logic [11:0] REG_ADDR        = 12'h008;     // Command target address
  localparam logic [11:0] REG_DATA        = 12'h00C;     // Program data
  localparam logic [11:0] REG_STATUS      = 12'h010;     // Selected partition status
  localparam logic [11:0] REG_ENGINE      = 12'h014;     // Engine state
  localparam logic [11:0] REG_OTP_SEL     = 12'h018;     // OTP word select
  localparam logic [11:0] REG_OTP_DATA    = 12'h01C;     // OTP word read

  // Read setup fields
  localparam int unsigned RS_SYNC         = 15;          // 1 = burst mode
  localparam int unsigned RS_LAT_LSB      = 11;          // Latency count [13:11]
  localparam int unsigned RS_WAIT_POL     = 10;          // Wait active high
  localparam int unsigned RS_HALF_RATE    = 9;           // Data every second clock
  localparam logic [15:0] RS_RESET        = 16'h0000;

  // Status fields
  localparam int unsigned ST_READY        = 7;
  localparam int unsigned ST_ERS_SUSP     = 6;
  localparam int unsigned ST_ERS_FAIL     = 5;
  localparam int unsigned ST_PRG_FAIL     = 4;
  localparam int unsigned ST_SUPPLY_LOW   = 3;
  localparam int unsigned ST_PRG_SUSP     = 2;
  localparam int unsigned ST_LOCKED       = 1;
  localparam logic [7:0]  ST_RESET        = 8'h80;

  // Commands
  typedef enum logic [3:0] {
    CMD_PROGRAM   = 4'h1,
    CMD_ERASE     = 4'h2,
    CMD_SUSPEND   = 4'h3,
    CMD_RESUME    = 4'h4,
    CMD_LOCK      = 4'h5,
    CMD_UNLOCK    = 4'h6,
    CMD_LOCKDOWN  = 4'h7,
    CMD_CLR_STAT  = 4'h8,
    CMD_OTP_PROG  = 4'h9
  } pfoc_cmd_e;

  // Write engine states
  typedef enum logic [2:0] {
    ENG_IDLE      = 3'b000,
    ENG_PROG      = 3'b001,
    ENG_ERASE     = 3'b010,
    ENG_ERS_SUSP  = 3'b011,
    ENG_NEST_PROG = 3'b100,
    ENG_BOTH_SUSP = 3'b101
  } pfoc_eng_e;

  // Host flash bus inputs
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              adv_n;
    logic [ADDR_W-1:0] addr;
  } pfoc_host_s;

  // Array read port
  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } pfoc_arr_s;
endpackage

// ### pfoc_properties.sv
// Port-level assertions for the flash operation control block
`timescale 1ns/1ns
`default_nettype none
module pfoc_properties (
  // Clock, reset and APB
  input wire logic                 mclk_in,
  input wire logic                 srst_in,
  input wire logic                 psel_in,
  input wire logic                 penable_in,
  input wire logic [11:0]          paddr_in,
  input wire logic                 pready_out,
  input wire logic                 pslverr_out,
  // Host pins
  input wire pfoc_pkg::pfoc_host_s host_in,
  input wire logic                 rst_n_in,
  input wire logic                 data_oe_out,
  input wire logic                 standby_out
);
  import pfoc_pkg::*;
  // One clock domain, so one default for all
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // Access phase, and an address outside the eight aligned words
  wire logic acc = psel_in && penable_in;
  wire logic bad = (paddr_in > 12'h01C) || (paddr_in[1:0] != 2'h0);
  a_ready_always: assert property (pready_out)
    else $error("pready low");
  a_err_access: assert property (pslverr_out |-> acc)
    else $error("pslverr outside access phase");
  a_err_bad: assert property (acc && bad |-> pslverr_out)
    else $error("bad address not refused");
  a_err_good: assert property (acc && !bad |-> !pslverr_out)
    else $error("mapped address refused");
  // Pins cross two sync flops and an output flop, so four cycles is just enough
  a_standby_deselect: assert property (host_in.ce_n [*4] |-> standby_out)
    else $error("no standby while deselected");
  a_standby_quiet: assert property (host_in.ce_n [*4] |-> !data_oe_out)
    else $error("data driven while deselected");
  a_standby_wake: assert property ((!host_in.ce_n && rst_n_in) [*4] |-> !standby_out)
    else $error("standby while selected");
  a_oe_quiet: assert property (host_in.oe_n [*4] |-> !data_oe_out)
    else $error("data driven with output enable off");
  // Main scenarios reached
  c_error: cover property (acc && pslverr_out);
  c_drive: cover property ($rose(data_oe_out));
  c_standby: cover property ($rose(standby_out));
endmodule
bind pfoc_top pfoc_properties pfoc_properties_i (
  .mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .host_in(host_in), .rst_n_in(rst_n_in), .data_oe_out(data_oe_out),
  .standby_out(standby_out)
);
`default_nettype wire

// ### pfoc_host_model.sv
// Host side model that runs one burst read on request
`timescale 1ns/1ns
`default_nettype none
module pfoc_host_model (
  // Clock and burst request
  input  wire logic                 mclk_in,
  input  wire logic                 go_in,
  input  wire logic [22:0]          addr_in,
  // Flash bus drive
  output var pfoc_pkg::pfoc_host_s  host_out,
  output var logic                  clk_out,
  output var logic                  busy_out
);
  // Burst clock stands still outside a burst
  initial begin
    host_out = '1;
    clk_out = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (go_in) begin
        // Select and offer the start address, latched on one clock edge
        busy_out <= 1'b1;
        host_out <= {3'h2, addr_in};
        repeat (4) @(posedge mclk_in);
        clk_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // Address released: show its inverse, not the last value
        host_out <= {3'h1, ~addr_in};
        clk_out <= 1'b0;
        // Sixteen valid clocks, then deselect; never runs on
        repeat (32) begin
          repeat (4) @(posedge mclk_in);
          clk_out <= ~clk_out;
        end
        host_out <= {3'h7, addr_in};
        busy_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_partitioned_flash_operation_control.sv
// Self-checking bench for the flash operation control block
`timescale 1ns/1ns
`default_nettype none
module tb_partitioned_flash_operation_control;
  import pfoc_pkg::*;
  // Drive, observe and bookkeeping
  logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        rst_n = 1'b1, supply_low = 1'b0, go = 1'b0, err, ps = 1'b0;
  logic [1:0]  dens = 2'h2;
  logic        pready, pslverr, data_oe, wt, standby, psave, bclk, hbusy;
  logic [22:0] baddr = 23'h0, maxa = 23'h0;
  logic [15:0] data, last = 16'h0;
  logic [7:0]  chg = 8'h0, full;
  pfoc_host_s  host;
  pfoc_arr_s   arr;
  int          error_cnt = 0, tests_run = 0;
  pfoc_top pfoc_top_i (
    .mclk_in(mclk), .srst_in(srst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .host_in(host), .burst_clk_in(bclk),
    .rst_n_in(rst_n), .supply_low_in(supply_low), .density_in(dens), .arr_out(arr),
    .arr_data_in(arr.addr[15:0]), .data_out(data), .data_oe_out(data_oe),
    .wait_out(wt), .standby_out(standby), .power_save_out(psave));
  pfoc_host_model pfoc_host_model_i (.mclk_in(mclk), .go_in(go), .addr_in(baddr),
    .host_out(host), .clk_out(bclk), .busy_out(hbusy));
  // 250 MHz core clock
  initial begin
    forever #2 mclk = ~mclk;
  end
  // Count word changes on the pins and the highest array address read
  always @(posedge mclk) begin
    if (data_oe === 1'b1 && data !== last) begin
      chg <= chg + 8'h01;
      last <= data;
    end
    if (arr.req === 1'b1 && arr.addr > maxa) maxa <= arr.addr;
    if (psave === 1'b1) ps <= 1'b1;
  end
  task automatic end_sim;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; answer taken at the edge pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [22:0] a);
    apb(1'b1, REG_ADDR, {9'h000, a});
    apb(1'b1, REG_CMD, {28'h0, c});
  endtask
  task automatic stat(input logic [4:0] p);
    apb(1'b1, REG_ADDR, {9'h000, p, 18'h0});
    apb(1'b0, REG_STATUS, 32'h0);
  endtask
  // Poll engine state, bounded well past one erase
  task automatic eng(input logic [2:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_ENGINE, 32'h0);
      n++;
    end while (rd[5:3] !== e && n < 3000);
    chk(rd[5:3], e);
  endtask
  task automatic t_defaults;
    apb(1'b0, REG_READ_SETUP, 32'h0);
    chk(rd[15:0], RS_RESET);
    dens <= 2'h0;
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[13:8], PARTS_32M);
    dens <= 2'h2;
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[13:8], PARTS_128M);
    stat(5'h00);
    chk(rd[7:0], ST_RESET);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h006, 32'h0);
    chk(err, 1'b1);
  endtask
  // Locked, unlocked and locked-down programs in partition 1
  task automatic t_lock;
    apb(1'b1, REG_DATA, 32'h1234);
    cmd(CMD_PROGRAM, 23'h040000);
    stat(5'h01);
    chk(rd[7:0], 8'h92);
    cmd(CMD_CLR_STAT, 23'h040000);
    cmd(CMD_UNLOCK, 23'h040000);
    cmd(CMD_PROGRAM, 23'h040000);
    stat(5'h01);
    chk(rd[7:0], 8'h00);
    stat(5'h00);
    chk(rd[7:0], 8'h80);
    eng(ENG_IDLE);
    stat(5'h01);
    chk(rd[7:0], 8'h80);
    cmd(CMD_LOCKDOWN, 23'h040000);
    cmd(CMD_UNLOCK, 23'h040000);
    cmd(CMD_PROGRAM, 23'h040000);
    stat(5'h01);
    chk(rd[7:0], 8'h92);
    cmd(CMD_CLR_STAT, 23'h040000);
  endtask
  task automatic burst;
    @(posedge mclk);
    go <= 1'b1;
    chg <= 8'h00;
    maxa <= 23'h0;
    @(posedge mclk);
    go <= 1'b0;
    do @(posedge mclk); while (hbusy === 1'b1);
    repeat (8) @(posedge mclk);
  endtask
  // Start just below a partition edge; no partition is busy
  task automatic t_burst;
    baddr = 23'h03FFF8;
    apb(1'b1, REG_READ_SETUP, 32'h9800);
    apb(1'b0, REG_READ_SETUP, 32'h0);
    chk(rd[15:0], 16'h9800);
    burst();
    chk(maxa[22:18], 5'h01);
    full = chg;
    chk(wt, 1'b1);
    apb(1'b1, REG_READ_SETUP, 32'h9E00);
    burst();
    chk(full > chg, 1'b1);
    chk(standby, 1'b1);
    chk(wt, 1'b0);
    chk(ps, 1'b1);
  endtask
  // Erase suspend with nested program and its suspend, partition 2
  task automatic t_suspend;
    cmd(CMD_UNLOCK, 23'h080000);
    cmd(CMD_UNLOCK, 23'h088000);
    cmd(CMD_UNLOCK, 23'h0C0000);
    cmd(CMD_ERASE, 23'h080000);
    cmd(CMD_ERASE, 23'h0C0000);
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[5:3], ENG_ERASE);
    stat(5'h03);
    chk(rd[7:0], 8'h80);
    cmd(CMD_SUSPEND, 23'h080000);
    eng(ENG_ERS_SUSP);
    stat(5'h02);
    chk(rd[7:6], 2'h3);
    cmd(CMD_PROGRAM, 23'h080000);
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[5:3], ENG_ERS_SUSP);
    cmd(CMD_PROGRAM, 23'h088000);
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[5:3], ENG_NEST_PROG);
    cmd(CMD_SUSPEND, 23'h088000);
    eng(ENG_BOTH_SUSP);
    cmd(CMD_RESUME, 23'h088000);
    eng(ENG_ERS_SUSP);
    cmd(CMD_RESUME, 23'h080000);
    eng(ENG_IDLE);
    stat(5'h02);
    chk(rd[7:6], 2'h2);
  endtask
  // Low supply refuses a program; reset pin clears status and setup
  task automatic t_supply;
    cmd(CMD_UNLOCK, 23'h048000);
    supply_low <= 1'b1;
    cmd(CMD_PROGRAM, 23'h048000);
    apb(1'b0, REG_ENGINE, 32'h0);
    chk(rd[5:3], ENG_IDLE);
    stat(5'h01);
    chk(rd[7:0], 8'h98);
    supply_low <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    stat(5'h01);
    chk(rd[7:0], ST_RESET);
    apb(1'b0, REG_READ_SETUP, 32'h0);
    chk(rd[15:0], RS_RESET);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_defaults();
    t_lock();
    t_burst();
    t_suspend();
    t_supply();
    end_sim();
  end
  // Hang guard, about five times the expected run
  initial begin
    #130000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
